// *** design/kbd_trap_pkg.sv ***
// Package with constants, types and register layout for the keyboard port trap.
package kbd_trap_pkg;
   localparam logic [15:0] DATA_PORT_ADDR = 16'h0060;
   localparam logic [15:0] CMD_PORT_ADDR = 16'h0064;
   localparam logic [7:0] GATE_CMD = 8'hD1;
   localparam logic [7:0] GATE_END = 8'hFF;
   // Register offsets on the software port.
   localparam logic [7:0] CFG_OFFSET = 8'hC0;
   localparam logic [7:0] STAT_OFFSET = 8'hC4;
   // Config register field positions.
   localparam int CFG_DATA_RD_BIT = 0;
   localparam int CFG_DATA_WR_BIT = 1;
   localparam int CFG_CMD_RD_BIT = 2;
   localparam int CFG_CMD_WR_BIT = 3;
   localparam int CFG_PSEQ_BIT = 6;
   localparam int CFG_END_SMI_BIT = 7;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [3:0] STAT_RESET = 4'h0;
   // Access type index: bit0 data rd, bit1 data wr, bit2 cmd rd, bit3 cmd wr.
   typedef enum {SEQ_IDLE, GATE_SEQ_FIRST, GATE_SEQ_SECOND} seq_state_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [7:0] data;
   } host_cycle_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
endpackage : kbd_trap_pkg

// *** design/kbd_access_decode.sv ***
// Decoder that turns a host cycle into one of four keyboard access types.
`timescale 1ns/10ps
`default_nettype none
module kbd_access_decode
   import kbd_trap_pkg::*;
(
   input wire host_cycle_t cyc,
   output logic [3:0] access_type
);
   // One-hot type; zero when the cycle misses both ports.
   always_comb begin
      access_type = 4'h0;
      if (cyc.valid && cyc.addr == DATA_PORT_ADDR) begin
         access_type[CFG_DATA_WR_BIT] = cyc.write;
         access_type[CFG_DATA_RD_BIT] = ~cyc.write;
      end else if (cyc.valid && cyc.addr == CMD_PORT_ADDR) begin
         access_type[CFG_CMD_WR_BIT] = cyc.write;
         access_type[CFG_CMD_RD_BIT] = ~cyc.write;
      end
   end
endmodule // kbd_access_decode
`default_nettype wire

// *** design/legacy_keyboard_port_trap.sv ***
// Keyboard port trap: access snooping, gate sequencer, chip select and trap interrupt.
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Watch reads and writes to data and command ports as four trap types.
// - Latch every access type into status regardless of its trap enable.
// - Raise trap interrupt before the host cycle is acknowledged ready.
// - Block cycles trapped by bits 3-0 by holding controller select inactive; bit 7 traps pass.
// - Idle plus command write D1h: go first gate, pass, no trap, flag set.
// - Idle keeps idle otherwise; config bits 3,2,1,0 govern per access type.
// - First gate, data write: go second gate, always pass, no trap.
// - First gate, command write D1h: stay, pass, no trap, flag set.
// - First gate, other command write: idle, clear flag, bit 3 or bit 7 trap.
// - First gate, data read: idle, clear flag, bit 0 or bit 7 trap.
// - Gate states, command read: stay, flag kept, trap if bit 2 set.
// - Second gate, command write FFh: idle, pass, clear flag, bit 7 trap.
// - Second gate, other command write: idle, clear flag, bit 3 or bit 7 trap.
// - Second gate, data write: idle, clear flag, bit 1 or bit 7 trap.
// - Second gate, data read: idle, clear flag, bit 0 or bit 7 trap.
// - Pass-sequence flag reads at config offset C0 bit 6.
module legacy_keyboard_port_trap
   import kbd_trap_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire host_cycle_t host_cyc,
   input wire reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   output logic kbc_chip_select,
   output logic mgmt_trap_interrupt_n,
   output logic host_target_ready
);
   typedef struct packed {
      seq_state_t seq;
      logic pass_sequence_flag;
      logic [7:0] cfg;
      logic [3:0] stat;
      logic [7:0] rdata;
      logic cs;
      logic smi_n;
      logic trdy;
      logic cyc_seen;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic [3:0] acc;
   logic pass;
   logic trap;
   logic [3:0] en;

   //////////////////////////////////////////////////////////////////////////
   // Access typing is shared combinational logic in a small leaf.
   kbd_access_decode u_decode (
      .cyc(host_cyc),
      .access_type(acc)
   );

   assign en = st_reg.cfg[3:0];

   //////////////////////////////////////////////////////////////////////////
   // Sequencer decision: pass means the cycle goes to the controller, trap
   // means the interrupt fires. Default per-type behaviour follows the enable.
   always_comb begin
      pass = ~|(acc & en);
      trap = |(acc & en);
      st_next = st_reg;
      case (st_reg.seq)
         SEQ_IDLE: begin
            if (acc[CFG_CMD_WR_BIT] && host_cyc.data == GATE_CMD) begin
               st_next.seq = GATE_SEQ_FIRST;
               st_next.pass_sequence_flag = 1'b1;
               pass = 1'b1;
               trap = 1'b0;
            end
         end
         GATE_SEQ_FIRST: begin
            if (acc[CFG_DATA_WR_BIT]) begin
               st_next.seq = GATE_SEQ_SECOND;
               pass = 1'b1;
               trap = 1'b0;
            end else if (acc[CFG_CMD_WR_BIT] && host_cyc.data == GATE_CMD) begin
               pass = 1'b1;
               trap = 1'b0;
            end else if (acc[CFG_CMD_WR_BIT] || acc[CFG_DATA_RD_BIT]) begin
               st_next.seq = SEQ_IDLE;
               st_next.pass_sequence_flag = 1'b0;
               trap = trap | st_reg.cfg[CFG_END_SMI_BIT];
            end
            // Command reads keep state and use the default bit 2 trap.
         end
         GATE_SEQ_SECOND: begin
            if (acc[CFG_CMD_WR_BIT] && host_cyc.data == GATE_END) begin
               st_next.seq = SEQ_IDLE;
               st_next.pass_sequence_flag = 1'b0;
               pass = 1'b1;
               trap = st_reg.cfg[CFG_END_SMI_BIT];
            end else if (acc[CFG_CMD_WR_BIT] || acc[CFG_DATA_WR_BIT]
                         || acc[CFG_DATA_RD_BIT]) begin
               st_next.seq = SEQ_IDLE;
               st_next.pass_sequence_flag = 1'b0;
               trap = trap | st_reg.cfg[CFG_END_SMI_BIT];
            end
            // Command reads fall to the default path here as well.
         end
         default: begin
            st_next.seq = SEQ_IDLE;
            st_next.pass_sequence_flag = 1'b0;
         end
      endcase
      // command reads in gate states leave state and flag alone.

      // Latch all types; enables decide only trap and select, not the status.
      st_next.stat = st_reg.stat | acc;
      if (reg_req.wr && reg_req.addr == STAT_OFFSET) begin
         // Write-one-to-clear; a new access in the same cycle wins.
         st_next.stat = (st_reg.stat & ~reg_req.wdata[3:0]) | acc;
      end
      if (reg_req.wr && reg_req.addr == CFG_OFFSET) begin
         st_next.cfg = reg_req.wdata;
      end

      // Select only for passed cycles; cycles trapped by bits 3-0 never reach the part, bit 7 traps do.
      st_next.cs = (|acc) & pass;
      // Interrupt is raised this edge, ready one edge later, so the
      // processor sees the interrupt before the cycle completes.
      st_next.smi_n = ~((|acc) & trap);
      st_next.cyc_seen = |acc;
      st_next.trdy = st_reg.cyc_seen;

      st_next.rdata = 8'h00;
      if (reg_req.rd) begin
         if (reg_req.addr == CFG_OFFSET) begin
            st_next.rdata = st_reg.cfg;
            st_next.rdata[CFG_PSEQ_BIT] = st_reg.pass_sequence_flag;
         end else if (reg_req.addr == STAT_OFFSET) begin
            st_next.rdata = {4'h0, st_reg.stat};
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // State register; reset gives idle, no flag, no latched source.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg.seq <= SEQ_IDLE;
         st_reg.pass_sequence_flag <= 1'b0;
         st_reg.cfg <= CFG_RESET;
         st_reg.stat <= STAT_RESET;
         st_reg.rdata <= 8'h00;
         st_reg.cs <= 1'b0;
         st_reg.smi_n <= 1'b1;
         st_reg.trdy <= 1'b0;
         st_reg.cyc_seen <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rdata;
   assign kbc_chip_select = st_reg.cs;
   assign mgmt_trap_interrupt_n = st_reg.smi_n;
   assign host_target_ready = st_reg.trdy;

   //////////////////////////////////////////////////////////////////////////
   // Checks.
   chk_idle_gate_entry: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_reg.seq == SEQ_IDLE && acc[CFG_CMD_WR_BIT] && host_cyc.data == GATE_CMD)
      |=> (st_reg.seq == GATE_SEQ_FIRST && st_reg.pass_sequence_flag
           && kbc_chip_select && mgmt_trap_interrupt_n))
      else $error("gate entry wrong");
   chk_stat_latch: assert property (@(posedge core_clk) disable iff (!rstn)
      acc[0] |=> st_reg.stat[0]) else $error("data read not latched");
   chk_stat_all_types: assert property (@(posedge core_clk) disable iff (!rstn)
      (|acc) |=> ((st_reg.stat & $past(acc)) == $past(acc)))
      else $error("access type not latched");
   chk_trap_before_ready: assert property (@(posedge core_clk) disable iff (!rstn)
      $fell(mgmt_trap_interrupt_n) |-> !host_target_ready ##1 host_target_ready)
      else $error("ready not after interrupt");
   chk_block_select: assert property (@(posedge core_clk) disable iff (!rstn)
      !mgmt_trap_interrupt_n && st_reg.seq == SEQ_IDLE && $past(st_reg.seq) == SEQ_IDLE
      |-> !kbc_chip_select) else $error("trapped cycle passed");
   chk_first_data_wr: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_reg.seq == GATE_SEQ_FIRST && acc[CFG_DATA_WR_BIT])
      |=> st_reg.seq == GATE_SEQ_SECOND && kbc_chip_select && mgmt_trap_interrupt_n)
      else $error("first gate data write wrong");
   chk_second_end: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_reg.seq == GATE_SEQ_SECOND && acc[CFG_CMD_WR_BIT]
       && host_cyc.data == GATE_END)
      |=> st_reg.seq == SEQ_IDLE && !st_reg.pass_sequence_flag && kbc_chip_select
          && (mgmt_trap_interrupt_n == !$past(st_reg.cfg[CFG_END_SMI_BIT])))
      else $error("sequence end wrong");
   chk_cmd_read_stay: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_reg.seq != SEQ_IDLE && acc[CFG_CMD_RD_BIT])
      |=> $stable(st_reg.seq) && st_reg.pass_sequence_flag
          && (mgmt_trap_interrupt_n == !$past(st_reg.cfg[CFG_CMD_RD_BIT])))
      else $error("command read in gate wrong");
   chk_abort_bit7: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_reg.seq == GATE_SEQ_SECOND && acc[CFG_DATA_RD_BIT]
       && st_reg.cfg[CFG_END_SMI_BIT])
      |=> !mgmt_trap_interrupt_n && st_reg.seq == SEQ_IDLE)
      else $error("abort interrupt missing");
   chk_flag_readback: assert property (@(posedge core_clk) disable iff (!rstn)
      (reg_req.rd && reg_req.addr == CFG_OFFSET)
      |=> reg_rdata[CFG_PSEQ_BIT] == $past(st_reg.pass_sequence_flag))
      else $error("flag readback wrong");
endmodule // legacy_keyboard_port_trap
`default_nettype wire

// *** verification/kbc_model.sv ***
// Model of the external keyboard controller that counts the selects it receives.
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module kbc_model (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic kbc_chip_select,
   output logic [7:0] cs_count
);
   // Each select is a one-cycle pulse, so every high sample is one passed cycle.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cs_count <= 8'h00;
      end else if (kbc_chip_select) begin
         cs_count <= cs_count + 8'h01;
      end
   end
endmodule // kbc_model
`default_nettype wire

// *** verification/legacy_keyboard_port_trap_test.sv ***
// Self-checking testbench for the keyboard port trap.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin errors++; \
   $display("BAD %s exp %h got %h", nm, ex, got); end end
module legacy_keyboard_port_trap_test;
   import kbd_trap_pkg::*;
   localparam logic [15:0] d_port = DATA_PORT_ADDR;
   localparam logic [15:0] c_port = CMD_PORT_ADDR;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   host_cycle_t host_cyc = '0;
   reg_req_t reg_req = '0;
   logic [7:0] reg_rdata;
   logic kbc_chip_select;
   logic mgmt_trap_interrupt_n;
   logic host_target_ready;
   logic [7:0] cs_count;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int exp_cs = 0;
   legacy_keyboard_port_trap legacy_keyboard_port_trap_inst (.core_clk(core_clk), .rstn(rstn),
      .host_cyc(host_cyc), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .kbc_chip_select(kbc_chip_select), .mgmt_trap_interrupt_n(mgmt_trap_interrupt_n),
      .host_target_ready(host_target_ready));
   kbc_model kbc_model_inst (.core_clk(core_clk), .rstn(rstn),
      .kbc_chip_select(kbc_chip_select), .cs_count(cs_count));
   //////////////////////////////////////////////////////////////////////////////
   // Clock at 200 MHz and a cycle ceiling well above the roughly 140 cycles used.
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         complete_run();
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // One host cycle; the trap must show before ready, which comes a cycle later.
   task automatic acc(input logic w, input logic [15:0] p, input logic [7:0] d,
                      input logic ecs, input logic eirq);
      @(posedge core_clk) host_cyc <= '{1'b1, w, p, d};
      @(posedge core_clk) host_cyc <= '{1'b0, 1'b0, 16'h0000, 8'h00};
      @(negedge core_clk);
      `CHK("cs", ecs, kbc_chip_select)
      `CHK("irq_n", ~eirq, mgmt_trap_interrupt_n)
      `CHK("early ready", 1'b0, host_target_ready)
      @(negedge core_clk);
      `CHK("ready", 1'b1, host_target_ready)
      if (ecs) exp_cs++;
   endtask
   // Register write and read; read data stand only in the cycle after the strobe.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk) reg_req <= '{a, d, 1'b1, 1'b0};
      @(posedge core_clk) reg_req <= '{8'h00, 8'h00, 1'b0, 1'b0};
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk) reg_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge core_clk) reg_req <= '{8'h00, 8'h00, 1'b0, 1'b0};
      @(negedge core_clk);
      `CHK("rdata", e, reg_rdata)
   endtask
   // Opens a gate sequence; even with the command-write trap on it passes quietly.
   task automatic open_seq();
      acc(1'b1, c_port, GATE_CMD, 1'b1, 1'b0);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      rd(CFG_OFFSET, 8'h00);
      rd(STAT_OFFSET, 8'h00);
      rd(8'h10, 8'h00);
      // Untrapped accesses in idle pass through but are still latched.
      acc(1'b1, c_port, 8'h20, 1'b1, 1'b0);
      acc(1'b0, c_port, 8'h00, 1'b1, 1'b0);
      acc(1'b1, d_port, 8'h33, 1'b1, 1'b0);
      acc(1'b0, d_port, 8'h00, 1'b1, 1'b0);
      rd(STAT_OFFSET, 8'h0F);
      wr(STAT_OFFSET, 8'h0F);
      rd(STAT_OFFSET, 8'h00);
      // All four traps on: every idle access other than command write D1h is blocked and interrupts.
      wr(CFG_OFFSET, 8'h0F);
      acc(1'b1, c_port, 8'h20, 1'b0, 1'b1);
      acc(1'b0, c_port, 8'h00, 1'b0, 1'b1);
      acc(1'b1, d_port, 8'h33, 1'b0, 1'b1);
      acc(1'b0, d_port, 8'h00, 1'b0, 1'b1);
      rd(STAT_OFFSET, 8'h0F);
      // Proper gate sequence with traps on, including a doubled command.
      open_seq();
      rd(CFG_OFFSET, 8'h4F);
      acc(1'b0, c_port, 8'h00, 1'b0, 1'b1);
      acc(1'b1, c_port, GATE_CMD, 1'b1, 1'b0);
      acc(1'b1, d_port, 8'hDF, 1'b1, 1'b0);
      rd(CFG_OFFSET, 8'h4F);
      acc(1'b0, c_port, 8'h00, 1'b0, 1'b1);
      acc(1'b1, c_port, GATE_END, 1'b1, 1'b0);
      rd(CFG_OFFSET, 8'h0F);
      // Traps off, end interrupt on: each bad or proper ending interrupts.
      wr(CFG_OFFSET, 8'h80);
      open_seq();
      acc(1'b0, d_port, 8'h00, 1'b1, 1'b1);
      open_seq();
      acc(1'b1, c_port, 8'h20, 1'b1, 1'b1);
      open_seq();
      acc(1'b1, d_port, 8'hDD, 1'b1, 1'b0);
      acc(1'b1, c_port, 8'h55, 1'b1, 1'b1);
      open_seq();
      acc(1'b1, d_port, 8'hDD, 1'b1, 1'b0);
      acc(1'b1, d_port, 8'h01, 1'b1, 1'b1);
      open_seq();
      acc(1'b1, d_port, 8'hDD, 1'b1, 1'b0);
      acc(1'b0, d_port, 8'h00, 1'b1, 1'b1);
      open_seq();
      rd(CFG_OFFSET, 8'hC0);
      acc(1'b1, d_port, 8'hDD, 1'b1, 1'b0);
      acc(1'b1, c_port, GATE_END, 1'b1, 1'b1);
      rd(CFG_OFFSET, 8'h80);
      // One enable at a time: only the matching access type is trapped.
      wr(CFG_OFFSET, 8'h02);
      acc(1'b1, d_port, 8'h44, 1'b0, 1'b1);
      acc(1'b0, d_port, 8'h00, 1'b1, 1'b0);
      wr(CFG_OFFSET, 8'h04);
      acc(1'b0, c_port, 8'h00, 1'b0, 1'b1);
      acc(1'b1, c_port, 8'h20, 1'b1, 1'b0);
      `CHK("cs_count", exp_cs[7:0], cs_count)
      complete_run();
   end
endmodule // legacy_keyboard_port_trap_test
`default_nettype wire
